// File: hdl/tcc_capture_top.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module tcc_capture_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] timer_count,
    input wire logic [tcc_pkg::GEAR_W-1:0] clock_gear,
    input wire logic ch6_trigger_pin,
    input wire logic ch7_trigger_pin,
    output logic capture_irq
);
    import tcc_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] cap_byte(input logic [31:0] val, input logic [1:0] sel);
        cap_byte = val[8 * (3 - sel) +: 8];
    endfunction

    function automatic logic [DIV_W-1:0] gear_mask(input logic [GEAR_W-1:0] gear);
        gear_mask = DIV_W'((4'h1 << gear) - 4'h1);
    endfunction

    localparam int STAT_BIT [NUM_CH] = '{STAT_CH6_BIT, STAT_CH7_BIT};
    localparam logic [IDX_W-1:0] CTRL_IDX [NUM_CH] = '{IDX_CH6_CTRL[IDX_W-1:0], IDX_CH7_CTRL[IDX_W-1:0]};
    localparam logic [IDX_W-1:0] VAL_IDX [NUM_CH] = '{IDX_CH6_VAL[IDX_W-1:0], IDX_CH7_VAL[IDX_W-1:0]};

    logic [7:0] ctrl_reg [NUM_CH];
    logic [31:0] cap_reg [NUM_CH];
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [7:0] mask_reg;
    logic [DIV_W-1:0] div_reg;
    logic tick_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic irq_reg;
    logic [NUM_CH-1:0] load;
    logic [NUM_CH-1:0] sel_ctrl;
    logic [NUM_CH-1:0] sel_val;
    logic [7:0] ch_rd [NUM_CH];

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic [IDX_W-1:0] word_idx = paddr[ADDR_W-1:2];
    wire logic sel_stat = word_idx == IDX_STATUS[IDX_W-1:0];
    wire logic sel_mask = word_idx == IDX_MASK[IDX_W-1:0];
    wire logic mapped = sel_stat || sel_mask || (|sel_ctrl) || (|sel_val);
    wire logic acc_done = psel && penable && pready_reg;
    wire logic wr_done = acc_done && pwrite && pstrb[0] && mapped;
    wire logic rd_done = acc_done && !pwrite && mapped;
    wire logic [7:0] rd_byte = sel_stat ? stat_reg : sel_mask ? mask_reg : (ch_rd[0] | ch_rd[1]);

    // ************************************************************
    // Gear divider: one fsys tick per gear period
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 1'b1;
            tick_reg <= (div_reg & gear_mask(clock_gear)) == gear_mask(clock_gear);
        end
    end

    // ************************************************************
    // Channels
    // ************************************************************
    wire logic [NUM_CH-1:0] pins = {ch7_trigger_pin, ch6_trigger_pin};

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        tcc_chan_if ch_if ();
        assign ch_if.filter_en = ctrl_reg[i][CTRL_FILT_BIT];
        assign ch_if.edge_sel = ctrl_reg[i][EDGE_W-1:0];
        assign ch_if.tick = tick_reg;
        assign sel_ctrl[i] = word_idx == CTRL_IDX[i];
        assign sel_val[i] = word_idx[IDX_W-1:2] == VAL_IDX[i][IDX_W-1:2];
        // Capture held off while this channel's value is on the bus
        assign load[i] = ch_if.hit && !(psel && sel_val[i]);
        assign ch_rd[i] = sel_ctrl[i] ? (ctrl_reg[i] & CTRL_IMPL_MASK)
            : sel_val[i] ? cap_byte(cap_reg[i], word_idx[1:0]) : 8'h00;

        tcc_channel u_channel (
            .pclk(pclk),
            .presetn(presetn),
            .trigger_pin(pins[i]),
            .cfg(ch_if.chan)
        );

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl_reg[i] <= CTRL_RESET;
            end else if (wr_done && sel_ctrl[i]) begin
                ctrl_reg[i] <= pwdata[7:0] & CTRL_IMPL_MASK;
            end
        end

        // No reset: content undefined until first capture
        always_ff @(posedge pclk) begin
            if (load[i]) begin
                cap_reg[i] <= timer_count;
            end
        end
    end

    // ************************************************************
    // Status, mask and interrupt
    // ************************************************************
    wire logic [7:0] load_bits = (8'(load[0]) << STAT_BIT[0]) | (8'(load[1]) << STAT_BIT[1]);
    // Read clears only the bits returned, so a flag set after the data latch survives
    wire logic [7:0] clr_bits = (rd_done && sel_stat) ? (prdata_reg[7:0] & STAT_CLR_MASK)
        : (wr_done && sel_stat) ? pwdata[7:0] : 8'h00;
    assign stat_next = ((stat_reg & ~clr_bits) | load_bits) & STAT_CLR_MASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= STAT_RESET;
            mask_reg <= MASK_RESET;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_reg <= |(stat_next & ~mask_reg);
            if (wr_done && sel_mask) begin
                mask_reg <= pwdata[7:0] & STAT_CLR_MASK;
            end
        end
    end

    // ************************************************************
    // APB slave: one wait state, read data latched with pready
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !mapped;
            if (psel && penable && !pready_reg) begin
                prdata_reg <= (pwrite || !mapped) ? 32'h00000000 : {24'h000000, rd_byte};
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign capture_irq = irq_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ch6_none_hold: assert property (!(load[0] && ctrl_reg[0][1:0] == TCC_EDGE_NONE))
        else $error("ch6 loaded with edge select none");
    a_ch7_none_hold: assert property (!(load[1] && ctrl_reg[1][1:0] == TCC_EDGE_NONE))
        else $error("ch7 loaded with edge select none");
    a_ctrl_rsvd_zero: assert property ((acc_done && !pwrite && (|sel_ctrl)) |-> prdata_reg[6:2] == 5'h00)
        else $error("control reserved bits not zero");
    a_read_block: assert property ((psel && sel_val[0]) |=> $stable(cap_reg[0]))
        else $error("ch6 captured during read");
    a_load_copy: assert property (load[1] |=> cap_reg[1] == $past(timer_count))
        else $error("capture value not the timer count");
    a_stat_flag: assert property (load[0] |=> stat_reg[STAT_CH6_BIT] ##1 1'b1)
        else $error("capture flag not set");
    a_stat_rdclr: assert property ((rd_done && sel_stat && load == '0) |=> (stat_reg & $past(prdata_reg[7:0])) == 8'h00)
        else $error("status not cleared by read");
    a_byte_order: assert property ((psel && penable && !pready_reg && !pwrite && sel_val[0] && word_idx[1:0] == 2'h0)
        |=> prdata_reg[7:0] == cap_reg[0][31:24])
        else $error("capture high byte not at lowest address");
    a_apb_wait: assert property ((psel && penable && !pready_reg) |=> pready_reg ##1 !pready_reg)
        else $error("pready not one cycle");
    c_ch6_cap: cover property (load[0]);
    c_ch7_cap: cover property (load[1]);
    c_stat_clear: cover property (rd_done && sel_stat && stat_reg != 8'h00);
    c_irq: cover property (irq_reg);
endmodule
`default_nettype wire

// File: hdl/tcc_pkg.sv
package tcc_pkg;
    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [31:0] IDX_STATUS = 32'hFFFFF408;
    localparam logic [31:0] IDX_MASK = 32'hFFFFF409;
    localparam logic [31:0] IDX_CH6_CTRL = 32'hFFFFF443;
    localparam logic [31:0] IDX_CH6_VAL = 32'hFFFFF444;
    localparam logic [31:0] IDX_CH7_CTRL = 32'hFFFFF44B;
    localparam logic [31:0] IDX_CH7_VAL = 32'hFFFFF44C;
    localparam int ADDR_W = 14;
    localparam int IDX_W = 12;
    localparam int NUM_CH = 2;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int CTRL_FILT_BIT = 7;
    localparam int EDGE_W = 2;
    localparam logic [7:0] CTRL_IMPL_MASK = 8'h83;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STAT_CLR_MASK = 8'h1F;
    localparam int STAT_CH6_BIT = 2;
    localparam int STAT_CH7_BIT = 3;

    typedef enum logic [EDGE_W-1:0] {
        TCC_EDGE_NONE = 2'h0,
        TCC_EDGE_RISE = 2'h1,
        TCC_EDGE_FALL = 2'h2,
        TCC_EDGE_BOTH = 2'h3
    } tcc_edge_e;

    // ************************************************************
    // Timing: noise threshold in system clock periods
    // ************************************************************
    localparam int FILTER_PERIODS = 4;
    localparam int FILT_CNT_W = 3;
    localparam int GEAR_W = 2;
    localparam int DIV_W = 3;
endpackage

// File: hdl/tcc_chan_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tcc_chan_if;
    import tcc_pkg::*;
    logic filter_en;
    logic [EDGE_W-1:0] edge_sel;
    logic tick;
    logic hit;
    modport chan (input filter_en, input edge_sel, input tick, output hit);
    modport ctrl (output filter_en, output edge_sel, output tick, input hit);
endinterface
`default_nettype wire

// File: hdl/tcc_channel.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trigger_pin,
    tcc_chan_if.chan cfg
);
    import tcc_pkg::*;

    // ************************************************************
    // Edge decode
    // ************************************************************
    function automatic logic edge_hit(input logic [EDGE_W-1:0] sel, input logic rise, input logic fall);
        edge_hit = ((sel == TCC_EDGE_RISE) && rise) || ((sel == TCC_EDGE_FALL) && fall)
            || ((sel == TCC_EDGE_BOTH) && (rise || fall));
    endfunction

    localparam logic [FILT_CNT_W-1:0] CNT_LAST = FILT_CNT_W'(FILTER_PERIODS - 1);

    logic sync1_reg;
    logic sync2_reg;
    logic filt_reg;
    logic [FILT_CNT_W-1:0] cnt_reg;
    logic prev_reg;
    logic hit_reg;
    wire logic differs = sync2_reg != filt_reg;
    wire logic accept = differs && cfg.tick && (cnt_reg == CNT_LAST);
    wire logic source = cfg.filter_en ? filt_reg : sync2_reg;
    wire logic rise = source && !prev_reg;
    wire logic fall = !source && prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= trigger_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // Level must persist four fsys ticks before it is accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (!cfg.filter_en || !differs) begin
            filt_reg <= sync2_reg;
            cnt_reg <= '0;
        end else if (accept) begin
            filt_reg <= sync2_reg;
            cnt_reg <= '0;
        end else if (cfg.tick) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
            hit_reg <= 1'b0;
        end else begin
            prev_reg <= source;
            hit_reg <= edge_hit(cfg.edge_sel, rise, fall);
        end
    end

    assign cfg.hit = hit_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_edge_decode: assert property (edge_hit(cfg.edge_sel, rise, fall) |=> hit_reg)
        else $error("qualified edge did not raise hit");
    a_none_no_hit: assert property ((cfg.edge_sel == TCC_EDGE_NONE) |=> !hit_reg)
        else $error("hit raised with edge select none");
    a_raw_path: assert property (!cfg.filter_en |-> source == sync2_reg)
        else $error("unfiltered path not direct");
    a_filter_width: assert property (($past(cfg.filter_en) && $changed(filt_reg)) |-> $past(cnt_reg) == CNT_LAST)
        else $error("filter accepted level early");
    a_filter_tick: assert property ((cfg.filter_en && $past(cfg.filter_en) && !$past(cfg.tick)) |-> $stable(filt_reg))
        else $error("filter moved without tick");
    c_filter_accept: cover property (cfg.filter_en && accept);
endmodule
`default_nettype wire

// File: verif/tcc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
    input wire logic pclk,
    output logic pin
);
    // ****
    // Idle low, high pulse on demand
    // ****
    initial pin = 1'b0;

    task automatic pulse(input int w);
        pin <= 1'b1;
        repeat (w) @(posedge pclk);
        pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verif/tb_tcc_capture_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_tcc_capture_top;
    import tcc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, capture_irq, pin6, pin7, err, hit;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, timer_count, rnd;
    logic [3:0] pstrb;
    logic [GEAR_W-1:0] clock_gear;
    logic [7:0] rd;
    logic [11:0] cidx, vidx;
    logic [31:0] expv [2];
    int failures, n_compared, cycles;

    tcc_capture_top i_tcc_capture_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_count(timer_count), .clock_gear(clock_gear), .ch6_trigger_pin(pin6),
        .ch7_trigger_pin(pin7), .capture_irq(capture_irq));
    tcc_pin_model i_tcc_pin_model6 (.pclk(pclk), .pin(pin6));
    tcc_pin_model i_tcc_pin_model7 (.pclk(pclk), .pin(pin7));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            conclude();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ****
    // APB transfer, waits for pready
    // ****
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                       output logic [7:0] r, output logic e);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) failures++;
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        pstrb = 4'hF; timer_count = '0; clock_gear = '0; rnd = 32'd90158;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // ****
        // Control reset, reserved bits, unmapped
        // ****
        apb(0, IDX_CH6_CTRL[11:0], 8'h00, rd, err); chk(rd, 8'h00);
        apb(1, IDX_CH6_CTRL[11:0], 8'hFF, rd, err);
        apb(0, IDX_CH6_CTRL[11:0], 8'h00, rd, err); chk(rd, 8'h83);
        apb(1, IDX_CH7_CTRL[11:0], 8'hFF, rd, err);
        apb(0, IDX_CH7_CTRL[11:0], 8'h00, rd, err); chk(rd, 8'h83);
        apb(0, 12'h000, 8'h00, rd, err); chk({err, rd}, 9'h100);
        pstrb <= 4'h0;
        apb(1, IDX_CH7_CTRL[11:0], 8'h00, rd, err);
        pstrb <= 4'hF;
        apb(0, IDX_CH7_CTRL[11:0], 8'h00, rd, err); chk(rd, 8'h83);
        apb(1, 12'h000, 8'h55, rd, err); chk(err, 1'b1);
        $display("register test done");
        // ****
        // Sweep channel, gear, edge, filter, width
        // ****
        for (int ch = 0; ch < 2; ch++)
            for (int g = 0; g < 4; g++)
                // Both edges first, so a value register is loaded before its first read
                for (int e = 3; e >= 0; e--)
                    for (int f = 0; f < 2; f++)
                        for (int s = 0; s < 2; s++) begin
                            cidx = ch ? IDX_CH7_CTRL[11:0] : IDX_CH6_CTRL[11:0];
                            vidx = ch ? IDX_CH7_VAL[11:0] : IDX_CH6_VAL[11:0];
                            apb(1, cidx, {f[0], 5'h00, e[1:0]}, rd, err);
                            rnd = lfsr(rnd);
                            clock_gear <= g[1:0];
                            timer_count <= rnd;
                            hit = (e != 0) && !(f == 1 && s == 0);
                            if (ch) i_tcc_pin_model7.pulse((s ? 6 : 2) << g);
                            else i_tcc_pin_model6.pulse((s ? 6 : 2) << g);
                            repeat (60) @(posedge pclk);
                            if (hit) expv[ch] = rnd;
                            chk(capture_irq, hit);
                            for (int b = 0; b < 4; b++) begin
                                apb(0, vidx + b[11:0], 8'h00, rd, err);
                                chk(rd, expv[ch][31-8*b -: 8]);
                            end
                            apb(0, IDX_STATUS[11:0], 8'h00, rd, err);
                            chk(rd, hit ? (8'h01 << (STAT_CH6_BIT + ch)) : 8'h00);
                        end
        $display("capture sweep done");
        // ****
        // Read-only values, mask and irq
        // ****
        apb(1, IDX_CH6_VAL[11:0], 8'h5A, rd, err);
        apb(0, IDX_CH6_VAL[11:0], 8'h00, rd, err); chk(rd, expv[0][31:24]);
        apb(1, IDX_CH7_VAL[11:0], 8'hA5, rd, err);
        apb(0, IDX_CH7_VAL[11:0], 8'h00, rd, err); chk(rd, expv[1][31:24]);
        apb(1, IDX_MASK[11:0], 8'h04, rd, err);
        apb(1, IDX_CH6_CTRL[11:0], 8'h01, rd, err);
        clock_gear <= 2'h0;
        i_tcc_pin_model6.pulse(6);
        repeat (30) @(posedge pclk);
        chk(capture_irq, 1'b0);
        apb(1, IDX_MASK[11:0], 8'h00, rd, err);
        repeat (3) @(posedge pclk);
        chk(capture_irq, 1'b1);
        apb(0, IDX_STATUS[11:0], 8'h00, rd, err); chk(rd, 8'h04);
        repeat (3) @(posedge pclk);
        chk(capture_irq, 1'b0);
        i_tcc_pin_model6.pulse(6);
        repeat (30) @(posedge pclk);
        chk(capture_irq, 1'b1);
        apb(1, IDX_STATUS[11:0], 8'h04, rd, err);
        apb(0, IDX_STATUS[11:0], 8'h00, rd, err); chk(rd, 8'h00);
        chk(capture_irq, 1'b0);
        $display("mask test done");
        conclude();
    end
endmodule
`default_nettype wire
